// ### shared/dce_pkg.sv
`default_nettype none
package dce_pkg;

	// ----------------------------------------------------------------
	// Event condition codes
	// ----------------------------------------------------------------
	localparam logic [2:0] COND_LOW      = 3'h0;
	localparam logic [2:0] COND_HIGH     = 3'h1;
	localparam logic [2:0] COND_TOGGLE   = 3'h2;
	localparam logic [2:0] COND_RISE     = 3'h3;
	localparam logic [2:0] COND_FALL     = 3'h4;
	localparam logic [2:0] COND_DB_TOGL  = 3'h5;
	localparam logic [2:0] COND_DB_RISE  = 3'h6;
	localparam logic [2:0] COND_DB_FALL  = 3'h7;

	// ----------------------------------------------------------------
	// Sampling sources
	// ----------------------------------------------------------------
	localparam logic [1:0] SRC_SYSCLK    = 2'h0;
	localparam logic [1:0] SRC_TIMER0    = 2'h1;
	localparam logic [1:0] SRC_TIMER1    = 2'h2;
	localparam logic [1:0] SRC_TIMER2    = 2'h3;

	// ----------------------------------------------------------------
	// Reference levels in millivolts, select codes 0..2; code 3 is open
	// ----------------------------------------------------------------
	localparam int         REF_LOW_MV    = 1125;
	localparam int         REF_MID_MV    = 1250;
	localparam int         REF_HIGH_MV   = 1375;
	localparam logic [1:0] REF_SEL_NONE  = 2'h3;

	// ----------------------------------------------------------------
	// Debounce timing and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] DBNC_T1_OVFS  = 2'h2;
	localparam logic [2:0] FILT_SAMPLES  = 3'h4;
	localparam logic       FLAG_RST      = 1'b0;

	// Pin select to one-hot switch enables, all open when unconnected
	function automatic logic [3:0] dce_pos_onehot(input logic en, input logic [1:0] sel);
		return en ? (4'h1 << sel) : 4'h0;
	endfunction : dce_pos_onehot

	// Reference select to one-hot switch enables
	function automatic logic [2:0] dce_ref_onehot(input logic en, input logic [1:0] sel);
		return (en && sel != REF_SEL_NONE) ? (3'h1 << sel) : 3'h0;
	endfunction : dce_ref_onehot

endpackage : dce_pkg
`default_nettype wire

// ### design/dce_rst_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dce_rst_sync (
	input  wire logic clk,
	input  wire logic rst_n,
	output logic      rst_sync_n
);
	logic meta_r;

	// Async assert, two-flop release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r     <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			meta_r     <= 1'b1;
			rst_sync_n <= meta_r;
		end
	end
endmodule : dce_rst_sync
`default_nettype wire

// ### design/dce_event_unit.sv
`timescale 1ns/1ps
`default_nettype none
module dce_event_unit
	import dce_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	input  wire logic       active,
	input  wire logic       raw,
	input  wire logic [2:0] cond_sel,
	input  wire logic       tick,
	input  wire logic       sys_sampling,
	input  wire logic       t1_ovf,
	input  wire logic       flag_clear,
	output logic            flag
);
	logic       prev_r;
	logic [2:0] stab_cnt_r;
	logic       pend_r;
	logic       expect_r;
	logic [1:0] ovf_cnt_r;

	// ----------------------------------------------------------------
	// Condition decode
	// ----------------------------------------------------------------
	wire       is_level  = (cond_sel == COND_LOW) || (cond_sel == COND_HIGH);
	wire       is_dbnc   = cond_sel >= COND_DB_TOGL;
	wire       want_rise = (cond_sel == COND_RISE) || (cond_sel == COND_DB_RISE) ||
	                       (cond_sel == COND_TOGGLE) || (cond_sel == COND_DB_TOGL);
	wire       want_fall = (cond_sel == COND_FALL) || (cond_sel == COND_DB_FALL) ||
	                       (cond_sel == COND_TOGGLE) || (cond_sel == COND_DB_TOGL);

	// Edge acceptance: four stable samples when timer-clocked debounce
	wire       filt      = is_dbnc && !sys_sampling;
	wire [2:0] thr       = filt ? FILT_SAMPLES : 3'h1;
	wire [2:0] cnt_inc   = 3'(stab_cnt_r + 3'h1);
	wire       diff      = raw != prev_r;
	wire       accept    = tick && diff && (cnt_inc >= thr);
	wire       rel_edge  = active && accept && (raw ? want_rise : want_fall);

	// Hits from level, plain edge and debounce validation
	wire       level_hit = active && tick && is_level && (raw == cond_sel[0]);
	wire       edge_hit  = rel_edge && !is_dbnc;
	wire       arm       = rel_edge && is_dbnc;
	wire       second    = pend_r && t1_ovf && (ovf_cnt_r == 2'(DBNC_T1_OVFS - 2'h1));
	wire       dbnc_hit  = second && active && (raw == expect_r);
	wire       set_hit   = level_hit || edge_hit || dbnc_hit;

	// Sticky flag, set wins over software clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			flag <= FLAG_RST;
		else if (clk_en)
			flag <= set_hit || (flag && !flag_clear);
	end

	// Sample history and stability count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_r     <= 1'b0;
			stab_cnt_r <= 3'h0;
		end else if (clk_en && tick) begin
			prev_r     <= accept ? raw : prev_r;
			stab_cnt_r <= (diff && !accept) ? cnt_inc : 3'h0;
		end
	end

	// Debounce wait on Timer 1; the arming overflow never counts
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_r    <= 1'b0;
			expect_r  <= 1'b0;
			ovf_cnt_r <= 2'h0;
		end else if (clk_en) begin
			if (!active || !is_dbnc) begin
				pend_r    <= 1'b0;
				ovf_cnt_r <= 2'h0;
			end else if (arm) begin
				pend_r    <= 1'b1;
				expect_r  <= raw;
				ovf_cnt_r <= 2'h0;
			end else if (second) begin
				pend_r    <= 1'b0;
				ovf_cnt_r <= 2'h0;
			end else if (pend_r && t1_ovf) begin
				ovf_cnt_r <= 2'(ovf_cnt_r + 2'h1);
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_dbnc_on_t1: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && is_dbnc && !flag && set_hit |-> t1_ovf && pend_r)
		else $error("debounced flag set without Timer 1 overflow");

	a_filter_four: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && filt && accept |-> stab_cnt_r == 3'h3)
		else $error("timer-clocked edge accepted before four samples");

	a_level_hit: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && active && tick && cond_sel == COND_HIGH && raw |=> flag)
		else $error("high level sample did not set flag");

	c_dbnc_flag: cover property (@(posedge clk) disable iff (!rst_n)
		clk_en && dbnc_hit);
endmodule : dce_event_unit
`default_nettype wire

// ### design/dce_dual_comparator.sv
// Function
// - Result reads one only when positive input exceeds negative, else zero.
// - Each comparator works only while its own enable bit is set.
// - Inputs connect only while the connect bit is set; software sets it first.
// - Three-bit condition selects level, edge or toggle; match sets the flag.
// - Hardware never clears flags; software polls and clears them.
// - Both flags drive one shared interrupt request.
// - Two-bit source samples on system clock or Timer 0, 1, 2 overflow.
// - Raw status bits always show live outputs, regardless of sampling.
// - Comparators keep running and flagging during idle mode.
// - Power-down forces both comparators inactive regardless of enables.
// - Two-bit select routes one of four analog pins to positive input.
// - Two-bit reference select picks one of three internal levels.
// - Three debounce modes apply only to edge conditions.
// - System-clock debounce waits two Timer 1 overflows, resamples, then flags.
// - Timer-clocked debounced edge accepted only after four consecutive stable samples; plain edges on first sample.
// - Timer-clocked debounce flags two Timer 1 overflows after the sampled event.
`timescale 1ns/1ps
`default_nettype none
module dce_dual_comparator
	import dce_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	input  wire logic       idle_mode,
	input  wire logic       power_down,
	input  wire logic       timer0_ovf,
	input  wire logic       timer1_ovf,
	input  wire logic       timer2_ovf,
	input  wire logic [1:0] sample_source_sel,
	input  wire logic       cmp_interrupt_enable,
	input  wire logic       cmp_a_enable,
	input  wire logic       cmp_a_connect,
	input  wire logic [2:0] cmp_a_event_condition_sel,
	input  wire logic [1:0] cmp_a_pos_input_sel,
	input  wire logic [1:0] cmp_a_ref_sel,
	input  wire logic       cmp_a_flag_clear,
	input  wire logic       cmp_a_analog_gt,
	input  wire logic       cmp_b_enable,
	input  wire logic       cmp_b_connect,
	input  wire logic [2:0] cmp_b_event_condition_sel,
	input  wire logic [1:0] cmp_b_pos_input_sel,
	input  wire logic [1:0] cmp_b_ref_sel,
	input  wire logic       cmp_b_flag_clear,
	input  wire logic       cmp_b_analog_gt,
	output logic            cmp_a_active,
	output logic            cmp_b_active,
	output logic [3:0]      cmp_a_pos_switch,
	output logic [3:0]      cmp_b_pos_switch,
	output logic [2:0]      cmp_a_ref_switch,
	output logic [2:0]      cmp_b_ref_switch,
	output logic            cmp_a_raw_out,
	output logic            cmp_b_raw_out,
	output logic            cmp_a_event_flag,
	output logic            cmp_b_event_flag,
	output logic            cmp_irq_req
);
	logic rst_sync_n;

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	dce_rst_sync u_rst_sync (
		.clk        (clk),
		.rst_n      (rst_n),
		.rst_sync_n (rst_sync_n)
	);

	// ----------------------------------------------------------------
	// Enable and power gating
	// ----------------------------------------------------------------
	// Idle does not gate; only power-down overrides the enables
	assign cmp_a_active = cmp_a_enable && !power_down;
	assign cmp_b_active = cmp_b_enable && !power_down;

	// ----------------------------------------------------------------
	// Analog switch control
	// ----------------------------------------------------------------
	// Positive input mux, open while disconnected
	assign cmp_a_pos_switch = dce_pos_onehot(cmp_a_connect, cmp_a_pos_input_sel);
	assign cmp_b_pos_switch = dce_pos_onehot(cmp_b_connect, cmp_b_pos_input_sel);

	// Negative input reference mux, open while disconnected
	assign cmp_a_ref_switch = dce_ref_onehot(cmp_a_connect, cmp_a_ref_sel);
	assign cmp_b_ref_switch = dce_ref_onehot(cmp_b_connect, cmp_b_ref_sel);

	// ----------------------------------------------------------------
	// Comparator results
	// ----------------------------------------------------------------
	// Result is one only when active and positive above negative
	wire res_a = cmp_a_analog_gt && cmp_a_active;
	wire res_b = cmp_b_analog_gt && cmp_b_active;

	// Live readback, independent of sampling source
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cmp_a_raw_out <= 1'b0;
			cmp_b_raw_out <= 1'b0;
		end else if (clk_en) begin
			cmp_a_raw_out <= res_a;
			cmp_b_raw_out <= res_b;
		end
	end

	// ----------------------------------------------------------------
	// Sampling source select
	// ----------------------------------------------------------------
	wire sys_sampling = sample_source_sel == SRC_SYSCLK;
	wire sample_tick  = sys_sampling                                 ? 1'b1       :
	                    (sample_source_sel == SRC_TIMER0)            ? timer0_ovf :
	                    (sample_source_sel == SRC_TIMER1)            ? timer1_ovf :
	                                                                   timer2_ovf;

	// ----------------------------------------------------------------
	// Event detection per comparator
	// ----------------------------------------------------------------
	dce_event_unit u_evt_a (
		.clk          (clk),
		.rst_n        (rst_sync_n),
		.clk_en       (clk_en),
		.active       (cmp_a_active),
		.raw          (res_a),
		.cond_sel     (cmp_a_event_condition_sel),
		.tick         (sample_tick),
		.sys_sampling (sys_sampling),
		.t1_ovf       (timer1_ovf),
		.flag_clear   (cmp_a_flag_clear),
		.flag         (cmp_a_event_flag)
	);

	dce_event_unit u_evt_b (
		.clk          (clk),
		.rst_n        (rst_sync_n),
		.clk_en       (clk_en),
		.active       (cmp_b_active),
		.raw          (res_b),
		.cond_sel     (cmp_b_event_condition_sel),
		.tick         (sample_tick),
		.sys_sampling (sys_sampling),
		.t1_ovf       (timer1_ovf),
		.flag_clear   (cmp_b_flag_clear),
		.flag         (cmp_b_event_flag)
	);

	// ----------------------------------------------------------------
	// Shared interrupt request
	// ----------------------------------------------------------------
	// Either flag requests; software reads both to find the source
	assign cmp_irq_req = (cmp_a_event_flag || cmp_b_event_flag) && cmp_interrupt_enable;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_pdown_inactive: assert property (@(posedge clk) disable iff (!rst_sync_n)
		power_down |-> !cmp_a_active && !cmp_b_active && !res_a && !res_b)
		else $error("comparator active in power-down");

	a_enable_gate: assert property (@(posedge clk) disable iff (!rst_sync_n)
		!cmp_a_enable && clk_en |=> !cmp_a_raw_out)
		else $error("disabled comparator A shows a result");

	a_idle_runs: assert property (@(posedge clk) disable iff (!rst_sync_n)
		idle_mode && cmp_b_enable && !power_down |-> cmp_b_active)
		else $error("comparator B stopped in idle");

	a_connect_gate: assert property (@(posedge clk) disable iff (!rst_sync_n)
		!cmp_a_connect |-> cmp_a_pos_switch == 4'h0 && cmp_a_ref_switch == 3'h0)
		else $error("comparator A inputs connected while connect is low");

	a_pos_route: assert property (@(posedge clk) disable iff (!rst_sync_n)
		cmp_b_connect |-> cmp_b_pos_switch[cmp_b_pos_input_sel] && $onehot(cmp_b_pos_switch))
		else $error("comparator B positive input misrouted");

	a_ref_route: assert property (@(posedge clk) disable iff (!rst_sync_n)
		cmp_a_connect && cmp_a_ref_sel != REF_SEL_NONE |-> $onehot(cmp_a_ref_switch) &&
		cmp_a_ref_switch[cmp_a_ref_sel])
		else $error("comparator A reference misrouted");

	a_raw_live: assert property (@(posedge clk) disable iff (!rst_sync_n)
		clk_en && sample_source_sel != SRC_SYSCLK |=> cmp_a_raw_out == $past(res_a))
		else $error("raw readback does not follow comparator A");

	a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_sync_n)
		$fell(cmp_a_event_flag) |-> $past(cmp_a_flag_clear) && $past(clk_en))
		else $error("flag A cleared without software clear");

	a_clear_lose: assert property (@(posedge clk) disable iff (!rst_sync_n)
		clk_en && cmp_b_active && sys_sampling && cmp_b_event_condition_sel == COND_LOW &&
		!res_b && cmp_b_flag_clear |=> cmp_b_event_flag)
		else $error("low level event lost against clear");

	a_irq_shared: assert property (@(posedge clk) disable iff (!rst_sync_n)
		$rose(cmp_b_event_flag) && cmp_interrupt_enable |-> cmp_irq_req)
		else $error("flag B did not raise shared request");

	a_tick_source: assert property (@(posedge clk) disable iff (!rst_sync_n)
		sample_source_sel == SRC_TIMER1 && !timer1_ovf |-> !sample_tick)
		else $error("sampling outside selected overflow");

	c_level_a: cover property (@(posedge clk) disable iff (!rst_sync_n)
		$rose(cmp_a_event_flag) && cmp_a_event_condition_sel == COND_HIGH);

	c_both_flags: cover property (@(posedge clk) disable iff (!rst_sync_n)
		cmp_a_event_flag && cmp_b_event_flag && cmp_irq_req);

	c_timer_edge: cover property (@(posedge clk) disable iff (!rst_sync_n)
		$rose(cmp_b_event_flag) && sample_source_sel == SRC_TIMER0);

endmodule : dce_dual_comparator
`default_nettype wire

// ### tb/dce_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module dce_analog_model
	import dce_pkg::*;
#(
	parameter int T0_P = 5,
	parameter int T1_P = 9,
	parameter int T2_P = 13
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [3:0][15:0] pin_mv,
	input  wire logic [3:0]       a_pos_sw,
	input  wire logic [3:0]       b_pos_sw,
	input  wire logic [2:0]       a_ref_sw,
	input  wire logic [2:0]       b_ref_sw,
	output logic                  a_gt,
	output logic                  b_gt,
	output logic                  t0_ovf,
	output logic                  t1_ovf,
	output logic                  t2_ovf
);
	int cnt;

	// Free-running timers with one-cycle overflow pulses
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt    <= 0;
			t0_ovf <= 1'b0;
			t1_ovf <= 1'b0;
			t2_ovf <= 1'b0;
		end else begin
			cnt    <= cnt + 1;
			t0_ovf <= (cnt % T0_P) == T0_P - 1;
			t1_ovf <= (cnt % T1_P) == T1_P - 1;
			t2_ovf <= (cnt % T2_P) == T2_P - 1;
		end
	end

	// Selected pin against selected level; open terminals chatter every cycle
	function automatic logic compare(input logic [3:0] ps, input logic [2:0] rs,
			input logic [3:0][15:0] mv, input logic noise);
		logic [15:0] pos;
		logic [15:0] neg;
		pos = ps[0] ? mv[0] : ps[1] ? mv[1] : ps[2] ? mv[2] : mv[3];
		neg = rs[0] ? 16'(REF_LOW_MV) : rs[1] ? 16'(REF_MID_MV) : 16'(REF_HIGH_MV);
		return (ps == 4'h0 || rs == 3'h0) ? noise : (pos > neg);
	endfunction : compare

	assign a_gt = compare(a_pos_sw, a_ref_sw, pin_mv, cnt[0]);
	assign b_gt = compare(b_pos_sw, b_ref_sw, pin_mv, ~cnt[0]);
endmodule : dce_analog_model
`default_nettype wire

// ### tb/tb_dual_comparator_event_logic.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dual_comparator_event_logic;
	import dce_pkg::*;
	logic             clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, idle_mode = 1'b0;
	logic             power_down = 1'b0, ie = 1'b0, clr_a = 1'b0, clr_b = 1'b0;
	logic             en_a = 1'b1, en_b = 1'b1, con_a = 1'b1, con_b = 1'b1, prev;
	logic [1:0]       src = SRC_SYSCLK, psel_a = 2'h0, psel_b = 2'h1;
	logic [1:0]       rsel_a = 2'h1, rsel_b = 2'h1;
	logic [2:0]       cond_a = COND_HIGH, cond_b = COND_LOW;
	logic [3:0][15:0] pin_mv = '0;
	logic             act_a, act_b, raw_a, raw_b, flag_a, flag_b, irq, gt_a, gt_b, t0, t1, t2;
	logic [3:0]       psw_a, psw_b;
	logic [2:0]       rsw_a, rsw_b;
	int               errors = 0, n_checks = 0, nt0, nt1;

	always #5 clk = ~clk;

	dce_dual_comparator u_dce_dual_comparator (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
		.idle_mode(idle_mode), .power_down(power_down), .timer0_ovf(t0), .timer1_ovf(t1),
		.timer2_ovf(t2), .sample_source_sel(src), .cmp_interrupt_enable(ie),
		.cmp_a_enable(en_a), .cmp_a_connect(con_a), .cmp_a_event_condition_sel(cond_a),
		.cmp_a_pos_input_sel(psel_a), .cmp_a_ref_sel(rsel_a), .cmp_a_flag_clear(clr_a),
		.cmp_a_analog_gt(gt_a), .cmp_b_enable(en_b), .cmp_b_connect(con_b),
		.cmp_b_event_condition_sel(cond_b), .cmp_b_pos_input_sel(psel_b),
		.cmp_b_ref_sel(rsel_b), .cmp_b_flag_clear(clr_b), .cmp_b_analog_gt(gt_b),
		.cmp_a_active(act_a), .cmp_b_active(act_b), .cmp_a_pos_switch(psw_a),
		.cmp_b_pos_switch(psw_b), .cmp_a_ref_switch(rsw_a), .cmp_b_ref_switch(rsw_b),
		.cmp_a_raw_out(raw_a), .cmp_b_raw_out(raw_b), .cmp_a_event_flag(flag_a),
		.cmp_b_event_flag(flag_b), .cmp_irq_req(irq));

	dce_analog_model u_dce_analog_model (.clk(clk), .rst_n(rst_n), .pin_mv(pin_mv),
		.a_pos_sw(psw_a), .b_pos_sw(psw_b), .a_ref_sw(rsw_a), .b_ref_sw(rsw_b),
		.a_gt(gt_a), .b_gt(gt_b), .t0_ovf(t0), .t1_ovf(t1), .t2_ovf(t2));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk1(input logic got, input logic exp, input string what);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask : chk1

	task automatic chkv(input logic [3:0] got, input logic [3:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chkv

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	function automatic logic [15:0] ref_mv(input logic [1:0] s);
		return (s == 2'h0) ? 16'(REF_LOW_MV) : (s == 2'h1) ? 16'(REF_MID_MV) : 16'(REF_HIGH_MV);
	endfunction : ref_mv

	function automatic logic src_tick(input logic [1:0] s);
		return (s == SRC_SYSCLK) ? 1'b1 : (s == SRC_TIMER0) ? t0 : (s == SRC_TIMER1) ? t1 : t2;
	endfunction : src_tick

	// Clear both flags with a one-cycle pulse
	task automatic clear();
		@(posedge clk);
		clr_a <= 1'b1;
		clr_b <= 1'b1;
		@(posedge clk);
		clr_a <= 1'b0;
		clr_b <= 1'b0;
	endtask : clear

	// Clear flag a, then move pin 0 on the next edge
	task automatic edge_to(input logic [15:0] mv);
		@(posedge clk);
		clr_a <= 1'b1;
		@(posedge clk);
		clr_a <= 1'b0;
		pin_mv[0] <= mv;
		tick(3);
	endtask : edge_to

	// Wait for n ticks of a source, bounded
	task automatic see(input logic [1:0] s, input int n);
		for (int k = 0; k < 200 && n > 0; k++) begin
			tick(1);
			n -= int'(src_tick(s));
		end
	endtask : see

	// Count overflows until flag a rises, bounded
	task automatic wait_flag();
		nt0 = 0;
		nt1 = 0;
		tick(1);
		for (int k = 0; k < 120 && flag_a !== 1'b1; k++) begin
			nt0 += int'(t0);
			nt1 += int'(t1);
			tick(1);
		end
	endtask : wait_flag

	task automatic results();
		$display("Checks %0d, errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(71));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		tick(3);
		// Random pin, mux and source mix; interrupt kept off while muxes move
		for (int i = 0; i < 40; i++) begin
			@(posedge clk);
			{con_a, con_b} <= 2'b00;
			@(posedge clk);
			psel_a <= 2'($urandom);
			psel_b <= 2'($urandom);
			rsel_a <= 2'($urandom_range(2));
			rsel_b <= 2'($urandom_range(2));
			src <= 2'($urandom);
			for (int k = 0; k < 4; k++) pin_mv[k] <= 16'($urandom_range(16'h05aa, 16'h041a));
			@(posedge clk);
			{con_a, con_b} <= 2'b11;
			clear();
			tick(1);
			chkv(psw_a, 4'h1 << psel_a, "pos switch a");
			chkv({1'b0, rsw_a}, 4'h1 << rsel_a, "ref switch a");
			chkv(psw_b, 4'h1 << psel_b, "pos switch b");
			chkv({1'b0, rsw_b}, 4'h1 << rsel_b, "ref switch b");
			chk1(raw_a, pin_mv[psel_a] > ref_mv(rsel_a), "raw a");
			chk1(raw_b, pin_mv[psel_b] > ref_mv(rsel_b), "raw b");
		end
		// Enable, connect, power-down and idle gating
		@(posedge clk);
		src <= SRC_SYSCLK;
		pin_mv <= {4{16'h0578}};
		{psel_a, rsel_a, psel_b, rsel_b} <= {2'h0, 2'h0, 2'h2, 2'h3};
		{en_a, con_b, cond_b} <= {1'b0, 1'b0, COND_HIGH};
		tick(2);
		chk1(act_a, 1'b0, "active a");
		chk1(raw_a, 1'b0, "raw a disabled");
		chkv(psw_b | {1'b0, rsw_b}, 4'h0, "switches b open");
		@(posedge clk);
		{en_a, con_b, rsel_b, power_down} <= {1'b1, 1'b1, 2'h0, 1'b1};
		clear();
		tick(3);
		chk1(act_b, 1'b0, "active b in power-down");
		chk1(flag_a | flag_b, 1'b0, "flags in power-down");
		@(posedge clk);
		{power_down, idle_mode} <= 2'b01;
		tick(3);
		chk1(flag_b, 1'b1, "flag b in idle");
		chk1(irq, 1'b0, "irq masked");
		@(posedge clk);
		{ie, cond_a, cond_b} <= {1'b1, COND_LOW, COND_LOW};
		tick(10);
		chk1(flag_a, 1'b1, "flag a sticky");
		chk1(irq, 1'b1, "irq shared");
		clear();
		tick(2);
		chk1(irq, 1'b0, "irq after clear");
		// Every plain condition through low, rise and fall
		@(posedge clk);
		{ie, rsel_a, pin_mv[0]} <= {1'b0, 2'h1, 16'h03e8};
		for (int c = 0; c < 5; c++) begin
			@(posedge clk);
			cond_a <= 3'(c);
			edge_to(16'h03e8);
			chk1(flag_a, c == 0, "steady low");
			edge_to(16'h0578);
			chk1(flag_a, c != 4, "after rise");
			edge_to(16'h03e8);
			chk1(flag_a, c != 3, "after fall");
		end
		// Level flag on each tick of every source, clear held
		@(posedge clk);
		{cond_a, pin_mv[0], clr_a} <= {COND_HIGH, 16'h0578, 1'b1};
		for (int s = 0; s < 4; s++) begin
			@(posedge clk);
			src <= 2'(s);
			tick(3);
			repeat (40) begin
				prev = src_tick(src);
				tick(1);
				chk1(flag_a, prev, "level flag per tick");
			end
		end
		// Debounced rise on system clock: glitch dropped, steady edge flagged
		@(posedge clk);
		{clr_a, src, cond_a, pin_mv[0]} <= {1'b0, SRC_SYSCLK, COND_DB_RISE, 16'h03e8};
		clear();
		@(posedge clk);
		pin_mv[0] <= 16'h0578;
		see(SRC_TIMER1, 1);
		@(posedge clk);
		pin_mv[0] <= 16'h03e8;
		tick(30);
		chk1(flag_a, 1'b0, "glitch dropped");
		@(posedge clk);
		pin_mv[0] <= 16'h0578;
		wait_flag();
		chk1(flag_a, 1'b1, "debounced flag");
		chk1(nt1 >= 2 && nt1 <= 3, 1'b1, "two timer1 overflows");
		// Debounced rise on timer 0 sampling
		@(posedge clk);
		{src, pin_mv[0]} <= {SRC_TIMER0, 16'h03e8};
		tick(30);
		clear();
		@(posedge clk);
		pin_mv[0] <= 16'h0578;
		see(SRC_TIMER0, 2);
		@(posedge clk);
		pin_mv[0] <= 16'h03e8;
		tick(80);
		chk1(flag_a, 1'b0, "short pulse filtered");
		@(posedge clk);
		pin_mv[0] <= 16'h0578;
		wait_flag();
		chk1(flag_a, 1'b1, "timer debounced flag");
		chk1(nt0 >= 4 && nt1 >= 2, 1'b1, "four samples then two overflows");
		results();
	end

	// Watchdog
	initial begin
		#50000;
		errors++;
		results();
	end
endmodule : tb_dual_comparator_event_logic
`default_nettype wire
